/* common/afc_chop_if.sv */
// Carries the chopper rate request to the divider and its tick back.
interface afc_chop_if;
    logic       run;  // Divider counts while high.
    logic [2:0] sel;  // Power-of-two divide select.
    logic       tick; // One-cycle pulse at the chopper rate.

    modport ctl (output run, output sel, input tick);
    modport div (input run, input sel, output tick);
endinterface

/* common/afc_pkg.sv */
// Behaviour
// - Sensor channel routes sensor and fixed level
// - Mode bit 0 enables the converter
// - Mode bit 1 selects supply-detect input
// - Mode bit 2 selects internal reference
// - Mode bit 3 selects wide internal span
// - Internal taps scale with analog supply
// - Supply detect uses divided supply taps; the code selects them only with internal reference
// - Result is signed word in two bytes
// - Result is ratio times 31250, signed
// - Gain field codes, others reserved
// - Chopper rate is clock/32/2^select
package afc_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses.
    // ------------------------------------------------------------------
    localparam logic [7:0] AMP_MODE_ADDR  = 8'h90; // Amplifier mode register.
    localparam logic [7:0] AMP_CHAN_ADDR  = 8'h91; // Amplifier channel register.
    localparam logic [7:0] CHOP_SEL_ADDR  = 8'h92; // Chopper clock select, write only.
    localparam logic [7:0] CONV_MODE_ADDR = 8'h93; // Converter mode register.
    localparam logic [7:0] RES_LOW_ADDR   = 8'h98; // Result low byte.
    localparam logic [7:0] RES_HIGH_ADDR  = 8'h99; // Result high byte.

    // ------------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------------
    localparam int CONV_EN_BIT    = 0; // Converter enable.
    localparam int CONV_INSRC_BIT = 1; // Input source select.
    localparam int CONV_REF_BIT   = 2; // Reference source select.
    localparam int CONV_SPAN_BIT  = 3; // Internal span select.
    localparam int AMP_EN_BIT     = 0; // Amplifier enable.
    localparam int AMP_GAIN_LSB   = 1; // Gain field low bit.
    localparam int AMP_CHOP_LSB   = 4; // Chopper low frequency field low bit.
    localparam int AMP_BG_BIT     = 6; // Band gap enable.

    localparam logic [7:0] AMP_MODE_RST  = 8'h0e; // Gain field resets to unity.
    localparam logic [7:0] CONV_MODE_RST = 8'h00; // Converter off after reset.
    localparam logic [2:0] CHAN_RST      = 3'h0;  // Differential channel.
    localparam logic [2:0] CHOP_SEL_RST  = 3'h0;  // Fastest chopper rate.

    // ------------------------------------------------------------------
    // Codes and counts.
    // ------------------------------------------------------------------
    localparam logic [2:0] CHAN_TEMP_SENSOR = 3'h5; // Temperature sensor channel.
    localparam logic [2:0] GAIN_MAX_LEGAL   = 3'h3; // Codes above this but below unity.
    localparam logic [2:0] GAIN_UNITY       = 3'h7; // Unity gain code.
    localparam int         CHOP_PRESCALE    = 32;   // Fixed chopper prescaler.
    localparam logic [15:0] FULL_SCALE_POS  = 16'h7a12; // Plus 31250.
    localparam logic [15:0] FULL_SCALE_NEG  = 16'h85ee; // Minus 31250.

endpackage

/* src/afc_chopper_div.sv */
// ----------------------------------------------------------------------
// Chopper rate divider.
// ----------------------------------------------------------------------
module afc_chopper_div #(
    parameter int PRESCALE = afc_pkg::CHOP_PRESCALE
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    afc_chop_if.div   ch
);
    // Wide enough for the prescaler times the largest power of two.
    localparam int CW = $clog2(PRESCALE * 128) + 1;

    // Elaboration stops on a prescaler that is not a power of two of at least 2.
    if (PRESCALE < 2 || (PRESCALE & (PRESCALE - 1)) != 0) begin : g_bad
        $error("PRESCALE must be a power of two of at least 2");
    end

    logic [CW-1:0] cnt_ff;   // Cycle counter.
    logic [CW-1:0] nxt_cnt;  // Next counter value.
    logic          tick_ff;  // Registered tick.
    logic          nxt_tick; // Next tick.
    logic [CW-1:0] limit;    // Last count of one period.

    assign limit   = (CW'(PRESCALE) << ch.sel) - CW'(1);
    assign ch.tick = tick_ff;

    // Count one period, pulse at its end; an idle divider restarts cleanly.
    always_comb begin
        nxt_cnt  = cnt_ff + CW'(1);
        nxt_tick = 1'b0;
        if (!ch.run) begin
            nxt_cnt = '0;
        end else if (cnt_ff >= limit) begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end
    end

    // Register the divider state.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    tick_period_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ch.run && cnt_ff == limit && $stable(ch.sel)) |=> tick_ff)
        else $error("chopper tick missing at period end");
    tick_single_a: assert property (@(posedge mclk) disable iff (!reset_n)
        tick_ff |-> (cnt_ff == '0))
        else $error("chopper tick not aligned to counter restart");
endmodule

/* src/afc_top.sv */
// ----------------------------------------------------------------------
// Analog front end control: mode registers, routing and result capture.
// ----------------------------------------------------------------------
//
// The plain strobed port was chosen for this implementation.
module afc_top (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [15:0] mod_result,
    input  wire logic        mod_valid,
    output logic             converter_enable,
    output logic             input_source_select,
    output logic             reference_source_select,
    output logic             internal_span_select,
    output logic             supply_tap_mode,
    output logic             amp_enable,
    output logic      [2:0]  gain_field,
    output logic             gain_reserved,
    output logic      [1:0]  chopper_low_freq_field,
    output logic             bandgap_enable,
    output logic      [2:0]  amp_channel,
    output logic             sensor_route,
    output logic             chopper_tick
);
    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------
    logic [6:0]  amp_mode_ff;      // Amplifier mode, bit 7 not stored.
    logic [6:0]  nxt_amp_mode;
    logic [2:0]  amp_chan_ff;      // Amplifier channel.
    logic [2:0]  nxt_amp_chan;
    logic [2:0]  chop_sel_ff;      // Chopper clock select.
    logic [2:0]  nxt_chop_sel;
    logic [3:0]  conv_mode_ff;     // Converter mode.
    logic [3:0]  nxt_conv_mode;
    logic [15:0] result_ff;        // Last accepted conversion word.
    logic [15:0] nxt_result;
    logic [7:0]  rdata_ff;         // Read data, valid the cycle after a read.
    logic [7:0]  nxt_rdata;
    logic        sensor_route_ff;  // Sensor routing to the amplifier outputs.
    logic        nxt_sensor_route;
    logic        supply_tap_ff;    // Supply-detect taps with internal reference.
    logic        nxt_supply_tap;
    logic        gain_rsv_ff;      // Reserved gain code present.
    logic        nxt_gain_rsv;
    logic        chop_tick_ff;     // Chopper tick, retimed.
    logic [15:0] clamped;          // Modulator word limited to full scale.

    afc_chop_if chop ();

    // ------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------
    // Writes land one edge after the strobe; the bus never waits.
    always_comb begin
        nxt_amp_mode  = amp_mode_ff;
        nxt_amp_chan  = amp_chan_ff;
        nxt_chop_sel  = chop_sel_ff;
        nxt_conv_mode = conv_mode_ff;
        if (reg_wr) begin
            unique case (reg_addr)
                afc_pkg::AMP_MODE_ADDR:  nxt_amp_mode  = reg_wdata[6:0];
                afc_pkg::AMP_CHAN_ADDR:  nxt_amp_chan  = reg_wdata[2:0];
                afc_pkg::CHOP_SEL_ADDR:  nxt_chop_sel  = reg_wdata[2:0];
                afc_pkg::CONV_MODE_ADDR: nxt_conv_mode = reg_wdata[3:0];
                default: ; // Writes elsewhere, results included, are ignored.
            endcase
        end
    end

    // Register the software-visible settings.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            amp_mode_ff  <= afc_pkg::AMP_MODE_RST[6:0];
            amp_chan_ff  <= afc_pkg::CHAN_RST;
            chop_sel_ff  <= afc_pkg::CHOP_SEL_RST;
            conv_mode_ff <= afc_pkg::CONV_MODE_RST[3:0];
        end else begin
            amp_mode_ff  <= nxt_amp_mode;
            amp_chan_ff  <= nxt_amp_chan;
            chop_sel_ff  <= nxt_chop_sel;
            conv_mode_ff <= nxt_conv_mode;
        end
    end

    // ------------------------------------------------------------------
    // Analog routing decode.
    // ------------------------------------------------------------------
    // Decodes are taken from the next values so that they change on the
    // same edge as the register, keeping every output a flip-flop.
    always_comb begin
        nxt_sensor_route = (nxt_amp_chan == afc_pkg::CHAN_TEMP_SENSOR);
        // Internal taps at three and two sixteenths of the supply.
        nxt_supply_tap = nxt_conv_mode[afc_pkg::CONV_INSRC_BIT]
                       & nxt_conv_mode[afc_pkg::CONV_REF_BIT];
        // Codes 100 to 110 name no gain.
        nxt_gain_rsv   = (nxt_amp_mode[3:1] > afc_pkg::GAIN_MAX_LEGAL)
                       && (nxt_amp_mode[3:1] != afc_pkg::GAIN_UNITY);
    end

    // Register the routing decode.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sensor_route_ff <= 1'b0;
            supply_tap_ff <= 1'b0;
            gain_rsv_ff   <= 1'b0;
        end else begin
            sensor_route_ff <= nxt_sensor_route;
            supply_tap_ff <= nxt_supply_tap;
            gain_rsv_ff   <= nxt_gain_rsv;
        end
    end

    // ------------------------------------------------------------------
    // Result capture.
    // ------------------------------------------------------------------
    // Words beyond plus or minus 31250 cannot be produced by a correct
    // ratio, so a modulator overshoot is clipped rather than wrapped.
    always_comb begin
        clamped = mod_result;
        if ($signed(mod_result) > $signed(afc_pkg::FULL_SCALE_POS)) begin
            clamped = afc_pkg::FULL_SCALE_POS;
        end else if ($signed(mod_result) < $signed(afc_pkg::FULL_SCALE_NEG)) begin
            clamped = afc_pkg::FULL_SCALE_NEG;
        end
        nxt_result = result_ff;
        // A disabled converter takes no new words.
        if (mod_valid && conv_mode_ff[afc_pkg::CONV_EN_BIT]) begin
            nxt_result = clamped;
        end
    end

    // Register the result word.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            result_ff <= '0;
        end else begin
            result_ff <= nxt_result;
        end
    end

    // ------------------------------------------------------------------
    // Register reads.
    // ------------------------------------------------------------------
    // The chopper select is write only and reads zero; unmapped reads zero.
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                afc_pkg::AMP_MODE_ADDR:  nxt_rdata = {1'b0, amp_mode_ff};
                afc_pkg::AMP_CHAN_ADDR:  nxt_rdata = {5'h00, amp_chan_ff};
                afc_pkg::CONV_MODE_ADDR: nxt_rdata = {4'h0, conv_mode_ff};
                afc_pkg::RES_LOW_ADDR:   nxt_rdata = result_ff[7:0];
                afc_pkg::RES_HIGH_ADDR:  nxt_rdata = result_ff[15:8];
                default:                 nxt_rdata = '0;
            endcase
        end
    end

    // Register read data; it stands only in the cycle after the strobe.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Chopper clock.
    // ------------------------------------------------------------------
    // The chopper runs only while the amplifier is enabled, saving power.
    assign chop.run = amp_mode_ff[afc_pkg::AMP_EN_BIT];
    assign chop.sel = chop_sel_ff;

    afc_chopper_div #(
        .PRESCALE (afc_pkg::CHOP_PRESCALE)
    ) u_div (
        .mclk    (mclk),
        .reset_n (reset_n),
        .ch      (chop)
    );

    // Retime the tick so the top output is a local flip-flop.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            chop_tick_ff <= 1'b0;
        end else begin
            chop_tick_ff <= chop.tick;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign reg_rdata               = rdata_ff;
    assign converter_enable        = conv_mode_ff[afc_pkg::CONV_EN_BIT];
    assign input_source_select     = conv_mode_ff[afc_pkg::CONV_INSRC_BIT];
    assign reference_source_select = conv_mode_ff[afc_pkg::CONV_REF_BIT];
    // The analog ladder scales both spans with the analog supply level.
    assign internal_span_select    = conv_mode_ff[afc_pkg::CONV_SPAN_BIT];
    assign supply_tap_mode         = supply_tap_ff;
    assign amp_enable              = amp_mode_ff[afc_pkg::AMP_EN_BIT];
    assign gain_field              = amp_mode_ff[3:1];
    assign gain_reserved           = gain_rsv_ff;
    assign chopper_low_freq_field  = amp_mode_ff[5:4];
    assign bandgap_enable          = amp_mode_ff[afc_pkg::AMP_BG_BIT];
    assign amp_channel             = amp_chan_ff;
    assign sensor_route            = sensor_route_ff;
    assign chopper_tick            = chop_tick_ff;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    sequence conv_write_s;
        reg_wr && reg_addr == afc_pkg::CONV_MODE_ADDR;
    endsequence
    sequence high_read_s;
        reg_rd && reg_addr == afc_pkg::RES_HIGH_ADDR;
    endsequence

    conv_enable_a: assert property (@(posedge mclk) disable iff (!reset_n)
        conv_write_s |=> converter_enable == $past(reg_wdata[0]))
        else $error("converter enable did not follow write");
    input_select_a: assert property (@(posedge mclk) disable iff (!reset_n)
        conv_write_s |=> input_source_select == $past(reg_wdata[1]))
        else $error("input select did not follow write");
    ref_select_a: assert property (@(posedge mclk) disable iff (!reset_n)
        conv_write_s |=> reference_source_select == $past(reg_wdata[2]))
        else $error("reference select did not follow write");
    span_select_a: assert property (@(posedge mclk) disable iff (!reset_n)
        conv_write_s |=> internal_span_select == $past(reg_wdata[3]))
        else $error("span select did not follow write");
    supply_tap_a: assert property (@(posedge mclk) disable iff (!reset_n)
        supply_tap_mode == (input_source_select && reference_source_select))
        else $error("supply tap mode inconsistent");
    sensor_route_a: assert property (@(posedge mclk) disable iff (!reset_n)
        sensor_route == (amp_channel == afc_pkg::CHAN_TEMP_SENSOR))
        else $error("sensor routing inconsistent with channel");
    gain_code_a: assert property (@(posedge mclk) disable iff (!reset_n)
        gain_reserved == (gain_field inside {3'h4, 3'h5, 3'h6}))
        else $error("reserved gain flag wrong");
    result_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !converter_enable |=> $stable(result_ff))
        else $error("result changed while converter disabled");
    result_range_a: assert property (@(posedge mclk) disable iff (!reset_n)
        ($signed(result_ff) <= 16'sd31250) && ($signed(result_ff) >= -16'sd31250))
        else $error("result beyond full scale");
    sign_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
        high_read_s ##1 1'b1 |-> reg_rdata[7] == $past(result_ff[15]))
        else $error("high byte sign bit wrong");
endmodule

/* tb/afc_mod_model.sv */
// ----------------------------------------------------------------------
// Modulator and filter stand-in: hands one signed word per request.
// ----------------------------------------------------------------------
module afc_mod_model (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        send,
    input  wire logic [15:0] word,
    output logic      [15:0] mod_result,
    output logic             mod_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Between words the result lines toggle every cycle, so a design that
    // captures without the valid pulse picks up garbage and is caught.
    always @(posedge mclk) begin
        if (!reset_n) begin
            mod_valid  <= 1'b0;
            mod_result <= 16'h0000;
        end else if (send) begin
            mod_valid  <= 1'b1;
            mod_result <= word;
        end else begin
            mod_valid  <= 1'b0;
            mod_result <= ~mod_result;
        end
    end
endmodule

/* tb/afc_top_tb.sv */
// ----------------------------------------------------------------------
// Self-checking bench for the analog front end control block.
// ----------------------------------------------------------------------
module afc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk      = 1'b0;  // 200 MHz clock.
    logic        reset_n   = 1'b0;  // Synchronous reset, active low.
    logic [7:0]  reg_addr  = 8'h00; // Register address.
    logic [7:0]  reg_wdata = 8'h00; // Write data.
    logic        reg_wr    = 1'b0;  // Write strobe.
    logic        reg_rd    = 1'b0;  // Read strobe.
    logic        send      = 1'b0;  // Asks the model for one word.
    logic [15:0] word      = 16'h0000; // Word the model hands over.
    logic [7:0]  reg_rdata;
    logic [15:0] mod_result;
    logic        mod_valid, converter_enable, input_source_select;
    logic        reference_source_select, internal_span_select, supply_tap_mode;
    logic        amp_enable, gain_reserved, bandgap_enable, sensor_route, chopper_tick;
    logic [2:0]  gain_field, amp_channel;
    logic [1:0]  chopper_low_freq_field;
    int          error_cnt   = 0;   // Mismatches seen.
    int          checks_done = 0;   // Comparisons made.
    logic [7:0]  rd_q[$];           // Expected read data, oldest first.
    logic        rd_pend = 1'b0;    // A read strobe was taken last edge.
    logic [7:0]  b;
    logic [15:0] w, e;
    int          n;
    logic [15:0] words[6] = '{16'h1234, 16'h7fff, 16'h8000, 16'h0000, 16'h7a13, 16'h85ee};

    always #2.5 mclk = ~mclk;

    afc_top uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_result(mod_result),
        .mod_valid(mod_valid), .converter_enable(converter_enable),
        .input_source_select(input_source_select),
        .reference_source_select(reference_source_select),
        .internal_span_select(internal_span_select), .supply_tap_mode(supply_tap_mode),
        .amp_enable(amp_enable), .gain_field(gain_field), .gain_reserved(gain_reserved),
        .chopper_low_freq_field(chopper_low_freq_field), .bandgap_enable(bandgap_enable),
        .amp_channel(amp_channel), .sensor_route(sensor_route), .chopper_tick(chopper_tick));

    afc_mod_model model (.mclk(mclk), .reset_n(reset_n), .send(send), .word(word),
        .mod_result(mod_result), .mod_valid(mod_valid));

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compares one value and counts it.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write; returns just after the edge that takes it, outputs settled.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle read; the expected byte is noted for the monitor.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(exp);
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask

    // Asks the model for one word.
    task automatic put(input logic [15:0] v);
        @(posedge mclk);
        send <= 1'b1;
        word <= v;
        @(posedge mclk);
        send <= 1'b0;
    endtask

    // Counts cycles to the next chopper pulse, under a bound.
    task automatic next_tick(output int cnt);
        cnt = 0;
        do begin
            @(posedge mclk);
            #1;
            cnt++;
        end while (chopper_tick !== 1'b1 && cnt < 5000);
        if (cnt >= 5000) begin
            error_cnt++;
            test_done();
        end
    endtask

    // Read data stand only in the cycle after the strobe: compare there.
    always @(posedge mclk) begin
        if (rd_pend) begin
            if (rd_q.size() == 0) begin
                check(16'hffff, 16'h0000);
            end else begin
                check({8'h00, reg_rdata}, {8'h00, rd_q.pop_front()});
            end
        end
        rd_pend <= reg_rd;
    end

    // Main sequence.
    initial begin
        void'($urandom(6));
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        check({13'h0, gain_field}, 16'h0007);
        check({converter_enable, amp_enable, bandgap_enable, sensor_route, amp_channel}, 16'h0000);
        rd(afc_pkg::AMP_MODE_ADDR, afc_pkg::AMP_MODE_RST);
        rd(afc_pkg::CONV_MODE_ADDR, afc_pkg::CONV_MODE_RST);
        rd(afc_pkg::RES_LOW_ADDR, 8'h00);
        rd(afc_pkg::RES_HIGH_ADDR, 8'h00);
        $display("Test reset values done");
        // Every combination of the four converter mode bits, junk above.
        for (int i = 0; i < 16; i++) begin
            b = {4'($urandom), 4'(i)};
            wr(afc_pkg::CONV_MODE_ADDR, b);
            check({15'h0, converter_enable}, {15'h0, b[0]});
            check({15'h0, input_source_select}, {15'h0, b[1]});
            check({15'h0, reference_source_select}, {15'h0, b[2]});
            check({15'h0, internal_span_select}, {15'h0, b[3]});
            check({15'h0, supply_tap_mode}, {15'h0, b[1] & b[2]});
            rd(afc_pkg::CONV_MODE_ADDR, {4'h0, b[3:0]});
        end
        $display("Test converter mode done");
        // Every gain code, with the reserved ones flagged.
        for (int g = 0; g < 8; g++) begin
            b = 8'($urandom);
            b[3:1] = 3'(g);
            b[0] = 1'b0;
            wr(afc_pkg::AMP_MODE_ADDR, b);
            check({13'h0, gain_field}, 16'(g));
            check({15'h0, gain_reserved}, {15'h0, g >= 4 && g <= 6});
            check({14'h0, chopper_low_freq_field}, {14'h0, b[5:4]});
            check({15'h0, bandgap_enable}, {15'h0, b[6]});
            rd(afc_pkg::AMP_MODE_ADDR, b & 8'h7f);
        end
        $display("Test amplifier mode done");
        // Every channel code; only the sensor code routes the sensor.
        for (int c = 0; c < 8; c++) begin
            b = 8'($urandom);
            b[2:0] = 3'(c);
            wr(afc_pkg::AMP_CHAN_ADDR, b);
            check({13'h0, amp_channel}, 16'(c));
            check({15'h0, sensor_route}, {15'h0, c == 5});
            rd(afc_pkg::AMP_CHAN_ADDR, {5'h0, 3'(c)});
        end
        $display("Test channel select done");
        // Band gap first; the pump and regulators are assumed up outside this block.
        wr(afc_pkg::AMP_MODE_ADDR, 8'h40);
        check({15'h0, bandgap_enable}, 16'h0001);
        // Settings go in with the enable bit low, the enable bit comes last.
        wr(afc_pkg::CHOP_SEL_ADDR, 8'h04);
        wr(afc_pkg::AMP_CHAN_ADDR, 8'h00);
        wr(afc_pkg::AMP_MODE_ADDR, 8'h76);
        check({15'h0, amp_enable}, 16'h0000);
        wr(afc_pkg::AMP_MODE_ADDR, 8'h77);
        check({15'h0, amp_enable}, 16'h0001);
        // Running amplifier switched to the sensor without a disable.
        wr(afc_pkg::AMP_MODE_ADDR, 8'h7f);
        wr(afc_pkg::AMP_CHAN_ADDR, 8'h05);
        check({amp_enable, sensor_route, gain_field}, 16'h001f);
        $display("Test sensor switch done");
        // Chopper period for several selects, the reference one among them.
        foreach (words[k]) begin
            if (k < 3) begin
                // Selects 0, 2 and 4; the last is the reference setting.
                wr(afc_pkg::CHOP_SEL_ADDR, 8'(k * 2));
                next_tick(n);
                next_tick(n);
                check(16'(n), 16'(32 << (k * 2)));
            end
        end
        rd(afc_pkg::CHOP_SEL_ADDR, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        $display("Test chopper and unmapped done");
        // Results: sign, clamp at full scale, then hold while disabled.
        wr(afc_pkg::CONV_MODE_ADDR, 8'h01);
        words[3] = 16'($urandom);
        for (int k = 0; k < 6; k++) begin
            w = words[k];
            e = w;
            if ($signed(w) > 31250) e = afc_pkg::FULL_SCALE_POS;
            if ($signed(w) < -31250) e = afc_pkg::FULL_SCALE_NEG;
            put(w);
            rd(afc_pkg::RES_LOW_ADDR, e[7:0]);
            rd(afc_pkg::RES_HIGH_ADDR, e[15:8]);
        end
        wr(afc_pkg::CONV_MODE_ADDR, 8'h00);
        put(16'h0bad);
        wr(afc_pkg::RES_HIGH_ADDR, 8'h12);
        rd(afc_pkg::RES_LOW_ADDR, e[7:0]);
        rd(afc_pkg::RES_HIGH_ADDR, e[15:8]);
        $display("Test result capture done");
        repeat (3) @(posedge mclk);
        check(16'(rd_q.size()), 16'h0000);
        test_done();
    end
endmodule
